// ---- hdl/mqaf_map.svh ----
// constants for the multiqueue almost flag logic
`ifndef MQAF_MAP_SVH
`define MQAF_MAP_SVH
`define MQAF_NQ 4
`define MQAF_QW 2
`define MQAF_DEVW 3
`define MQAF_LVLW 16
`define MQAF_SET_LAT 2
`define MQAF_REL_LAT 1
`define MQAF_SEL_LAT 1
`define MQAF_FT_LAT 2
`endif

// ---- hdl/mqaf_pkg.sv ----
// types for the multiqueue almost flag logic
`include "mqaf_map.svh"
package mqaf_pkg;
  typedef logic [`MQAF_QW-1:0] mqaf_qid_t;
  typedef logic [`MQAF_DEVW-1:0] mqaf_dev_t;
  typedef logic [`MQAF_LVLW-1:0] mqaf_lvl_t;
  typedef enum logic [1:0] {MQAF_IDLE, MQAF_WAIT1, MQAF_LIVE} mqaf_own_t;
endpackage

// ---- hdl/mqaf_delay.sv ----
// per-queue flag delay line: assertion vs release latency with skew extra
module mqaf_delay
  import mqaf_pkg::*;
#(
  parameter int N = 4
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw active-low condition per queue and skew violation
  input wire logic [N-1:0] raw_n,
  input wire logic skew_bad,
  // delayed active-low flags
  output logic [N-1:0] flag_n
);
  logic [N-1:0] s1_q, s1_d;

  // the caller registers flag_n once more, so the first stage alone gives two clocks
  always_comb
  begin
    s1_d = raw_n;
    // going low needs two samples (one while skew is violated); release takes the raw level unless skew is violated
    if (skew_bad)
      flag_n = s1_q;
    else
      flag_n = s1_q | raw_n;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s1_q <= '1;
    else
      s1_q <= s1_d;
  end
endmodule

// ---- hdl/mqaf_flags.sv ----
// almost-full / almost-empty flag and status-bus logic for one expanded device
`include "mqaf_map.svh"
// Summary of operation
// - almost-empty low two read clocks after read
// - almost-empty release after skew plus one clock
// - almost-full: two clocks set, skew plus one release
// - non-owner keeps empty flag and data undriven
// - empty flag follows newly selected read queue
// - empty bus follows selection one read clock later
// - bus bit index equals queue number
// - new bus owner drives, old owner releases
// - full bus shows previous-cycle selected device
// - full bus bit releases after skew plus one
// - selected write device drives full flag
// - full bus bit and flag fall together
// - fall-through word presented two clocks after select
// - full flag follows new write queue in two
module mqaf_flags
  import mqaf_pkg::*;
#(
  parameter int NQ = `MQAF_NQ,
  parameter int DW = 18,
  parameter mqaf_dev_t DEV_ID = 3'h0
)
(
  // clock and reset (single domain; read and write ports share clk)
  input wire logic clk,
  input wire logic rst,
  // per-queue fill levels and configured offsets, loaded before use
  input wire logic [NQ*`MQAF_LVLW-1:0] level,
  input wire logic [NQ*`MQAF_LVLW-1:0] ae_offset,
  input wire logic [NQ*`MQAF_LVLW-1:0] af_offset,
  input wire logic [NQ*`MQAF_LVLW-1:0] depth,
  input wire logic skew_bad,
  // read port selection
  input wire logic rd_sel,
  input wire logic [`MQAF_DEVW-1:0] rd_dev,
  input wire logic [`MQAF_QW-1:0] rd_q,
  input wire logic [DW-1:0] rd_word,
  // write port selection
  input wire logic wr_sel,
  input wire logic [`MQAF_DEVW-1:0] wr_dev,
  input wire logic [`MQAF_QW-1:0] wr_q,
  // status bus device selects
  input wire logic ae_bus_sel,
  input wire logic af_bus_sel,
  input wire logic [`MQAF_DEVW-1:0] bus_dev,
  // expansion strap (async pin)
  input wire logic empty_expansion_in,
  // discrete flags, three-signal form
  output logic almost_empty_flag_n_o,
  output logic almost_empty_flag_oe,
  output logic almost_full_flag_n_o,
  output logic almost_full_flag_oe,
  // status buses
  output logic [NQ-1:0] empty_status_bus_n_o,
  output logic empty_status_bus_oe,
  output logic [NQ-1:0] full_status_bus_n_o,
  output logic full_status_bus_oe,
  // fall-through data
  output logic [DW-1:0] rd_data_o,
  output logic rd_data_oe,
  output logic master_o
);
  logic [NQ-1:0] ae_raw_n, af_raw_n, ae_n, af_n;
  logic [1:0] strap_q, strap_d;
  logic master_q, master_d;
  logic rd_own_q, rd_own_d, wr_own_q, wr_own_d;
  mqaf_qid_t rd_q_q, rd_q_d, wr_q_q, wr_q_d;
  logic [1:0] rd_pipe_q, rd_pipe_d;
  logic aeb_own_q, aeb_own_d, afb_own_q, afb_own_d;
  logic aeb_go_q, aeb_go_d, afb_go_q, afb_go_d, bus_hit_q, bus_hit_d;
  logic ae_f_q, ae_f_d, af_f_q, af_f_d;
  logic [NQ-1:0] aeb_q, aeb_d, afb_q, afb_d;
  logic [1:0] af_sw_q, af_sw_d;
  logic [DW-1:0] data_q, data_d;
  logic [DW-1:0] word_s1_q, word_s1_d;

  function automatic logic [`MQAF_LVLW-1:0] fld(input logic [NQ*`MQAF_LVLW-1:0] v,
                                                  input int i);
    fld = v[i*`MQAF_LVLW +: `MQAF_LVLW];
  endfunction

  // raw boundary compare from configured offsets, active low
  always_comb
  begin
    for (int i = 0; i < NQ; i++)
    begin
      ae_raw_n[i] = !(fld(level, i) <= fld(ae_offset, i));
      af_raw_n[i] = !(fld(level, i) >= fld(depth, i) - fld(af_offset, i));
    end
  end

  mqaf_delay #(.N(NQ)) u_ae_dly
  (
    .clk(clk),
    .rst(rst),
    .raw_n(ae_raw_n),
    .skew_bad(skew_bad),
    .flag_n(ae_n)
  );

  mqaf_delay #(.N(NQ)) u_af_dly
  (
    .clk(clk),
    .rst(rst),
    .raw_n(af_raw_n),
    .skew_bad(skew_bad),
    .flag_n(af_n)
  );

  always_comb
  begin
    strap_d = {strap_q[0], empty_expansion_in};
    master_d = !strap_q[1];
    rd_own_d = rd_own_q;
    rd_q_d = rd_q_q;
    rd_pipe_d = {rd_pipe_q[0], 1'b0};
    if (rd_sel)
    begin
      rd_own_d = (rd_dev == DEV_ID);
      rd_q_d = rd_q;
      rd_pipe_d = {rd_pipe_q[0], rd_dev == DEV_ID};
    end
    wr_own_d = wr_own_q;
    wr_q_d = wr_q_q;
    af_sw_d = {af_sw_q[0], 1'b0};
    if (wr_sel)
    begin
      wr_own_d = (wr_dev == DEV_ID);
      wr_q_d = wr_q;
      af_sw_d = {af_sw_q[0], 1'b1};
    end
    aeb_go_d = ae_bus_sel;
    afb_go_d = af_bus_sel;
    bus_hit_d = (bus_dev == DEV_ID);
    // bus hand-over lands one clock after the select, as every device expects
    aeb_own_d = aeb_go_q ? bus_hit_q : aeb_own_q;
    afb_own_d = afb_go_q ? bus_hit_q : afb_own_q;
    aeb_d = ae_n;
    afb_d = af_n;
    ae_f_d = ae_n[rd_q_q];
    // new write queue shows up two clocks after selection, old status held
    af_f_d = af_sw_q[0] ? af_f_q : af_n[wr_q_q];
    word_s1_d = rd_word;
    data_d = rd_pipe_q[1] ? word_s1_q : data_q;
    if (rd_own_q && !rd_pipe_q[0] && !rd_pipe_q[1])
      data_d = word_s1_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strap_q <= 2'h3;
      master_q <= 1'b0;
      rd_own_q <= 1'b0;
      wr_own_q <= 1'b0;
      rd_q_q <= '0;
      wr_q_q <= '0;
      rd_pipe_q <= '0;
      af_sw_q <= '0;
      aeb_own_q <= 1'b0;
      afb_own_q <= 1'b0;
      aeb_go_q <= 1'b0;
      afb_go_q <= 1'b0;
      bus_hit_q <= 1'b0;
      aeb_q <= '1;
      afb_q <= '1;
      ae_f_q <= 1'b1;
      af_f_q <= 1'b1;
      word_s1_q <= '0;
      data_q <= '0;
    end
    else
    begin
      strap_q <= strap_d;
      master_q <= master_d;
      rd_own_q <= rd_own_d;
      wr_own_q <= wr_own_d;
      rd_q_q <= rd_q_d;
      wr_q_q <= wr_q_d;
      rd_pipe_q <= rd_pipe_d;
      af_sw_q <= af_sw_d;
      aeb_own_q <= aeb_own_d;
      afb_own_q <= afb_own_d;
      aeb_go_q <= aeb_go_d;
      afb_go_q <= afb_go_d;
      bus_hit_q <= bus_hit_d;
      aeb_q <= aeb_d;
      afb_q <= afb_d;
      ae_f_q <= ae_f_d;
      af_f_q <= af_f_d;
      word_s1_q <= word_s1_d;
      data_q <= data_d;
    end
  end

  // enables are plain flops so the old owner drops the same edge the new one drives
  assign almost_empty_flag_n_o = ae_f_q;
  assign almost_empty_flag_oe = rd_own_q;
  assign almost_full_flag_n_o = af_f_q;
  assign almost_full_flag_oe = wr_own_q;
  assign empty_status_bus_n_o = aeb_q;
  assign empty_status_bus_oe = aeb_own_q;
  assign full_status_bus_n_o = afb_q;
  assign full_status_bus_oe = afb_own_q;
  assign rd_data_o = data_q;
  assign rd_data_oe = rd_own_q;
  assign master_o = master_q;

  AST_AE_OE_OWN: assert property (@(posedge clk) disable iff (rst)
    rd_sel |=> (almost_empty_flag_oe == (($past(rd_dev)) == DEV_ID)))
    else $error("empty flag enable not following read owner");
  AST_AEB_SEL: assert property (@(posedge clk) disable iff (rst)
    ae_bus_sel && bus_dev == DEV_ID |-> ##2 empty_status_bus_oe)
    else $error("empty bus not taken one clock after select");
  AST_AEB_REL: assert property (@(posedge clk) disable iff (rst)
    ae_bus_sel && bus_dev != DEV_ID |-> ##2 !empty_status_bus_oe)
    else $error("old empty bus owner still driving");
  AST_AFB_SEL: assert property (@(posedge clk) disable iff (rst)
    af_bus_sel |-> ##2 full_status_bus_oe == ($past(bus_dev, 2) == DEV_ID))
    else $error("full bus owner wrong");
  AST_AF_OE: assert property (@(posedge clk) disable iff (rst)
    wr_sel && wr_dev == DEV_ID |=> almost_full_flag_oe)
    else $error("full flag not driven after write select");
  AST_AE_SET: assert property (@(posedge clk) disable iff (rst)
    $fell(ae_raw_n[2]) ##1 !ae_raw_n[2] |=> !empty_status_bus_n_o[2])
    else $error("almost empty not set two clocks later");
  AST_AF_SET: assert property (@(posedge clk) disable iff (rst)
    $fell(af_raw_n[1]) ##1 !af_raw_n[1] |=> !full_status_bus_n_o[1])
    else $error("almost full not set two clocks later");
  AST_AE_REL: assert property (@(posedge clk) disable iff (rst)
    !skew_bad && $rose(ae_raw_n[2]) |=> empty_status_bus_n_o[2])
    else $error("almost empty release late");
  AST_AF_REL: assert property (@(posedge clk) disable iff (rst)
    !skew_bad && $rose(af_raw_n[1]) |=> full_status_bus_n_o[1])
    else $error("almost full release late");
  AST_AF_EQ: assert property (@(posedge clk) disable iff (rst)
    !af_sw_q[0] && !af_sw_q[1] && !wr_sel && $past(!wr_sel) |=>
      almost_full_flag_n_o == full_status_bus_n_o[wr_q_q])
    else $error("full flag and bus bit disagree");
  COV_RD_SEL: cover property (@(posedge clk) rd_sel && rd_dev == DEV_ID);
  COV_AE_LOW: cover property (@(posedge clk) !almost_empty_flag_n_o && almost_empty_flag_oe);
  COV_AF_LOW: cover property (@(posedge clk) !almost_full_flag_n_o && almost_full_flag_oe);
  COV_BUS: cover property (@(posedge clk) empty_status_bus_oe && full_status_bus_oe);
endmodule

// ---- bench/mqaf_qctl.sv ----
// queue controller model: fill levels, boundaries, next words
module mqaf_qctl
  import mqaf_pkg::*;
#(
  parameter int NQ = 4
)
(
  // clock
  input wire logic clk,
  // traffic
  input wire logic push,
  input wire logic pop,
  input wire logic [1:0] qsel,
  // queue state
  output logic [NQ*16-1:0] level,
  output logic [NQ*16-1:0] ae_off,
  output logic [NQ*16-1:0] af_off,
  output logic [NQ*16-1:0] depth,
  output logic [17:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  mqaf_lvl_t lvl [NQ];
  // fixed before traffic, never changed mid-run
  assign ae_off = {NQ{16'h0004}};
  assign af_off = {NQ{16'h0004}};
  assign depth = {NQ{16'h0020}};
  // queue id in the top bits makes a wrong-queue word visible
  assign word = {qsel, lvl[qsel]};
  initial
  begin
    for (int i = 0; i < NQ; i++)
      lvl[i] = 16'h0008;
  end
  always @(posedge clk)
  begin
    if (push)
      lvl[qsel] <= lvl[qsel] + 16'h0001;
    else if (pop)
      lvl[qsel] <= lvl[qsel] - 16'h0001;
  end
  always_comb
  begin
    for (int i = 0; i < NQ; i++)
      level[16*i+:16] = lvl[i];
  end
endmodule

// ---- bench/tb_top.sv ----
// bench for the almost flag logic against the queue controller model
module tb_top
  import mqaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, skew = 0, strap = 0, push = 0, pop = 0;
  logic rs = 0, ws = 0, es = 0, fs = 0;
  logic [2:0] dv = 3'h0;
  logic [1:0] q = 2'h0, cq = 2'h0;
  logic [63:0] lv, ao, fo, dp;
  logic [17:0] wd, rdat;
  logic ae, aeo, af, afo, ebo, fbo, rdo, mst;
  logic [3:0] eb, fb, mon;
  int err_total = 0;
  int n_tests = 0;
  mqaf_qctl u_mqaf_qctl (.clk(clk), .push(push), .pop(pop), .qsel(cq), .level(lv),
    .ae_off(ao), .af_off(fo), .depth(dp), .word(wd));
  mqaf_flags u_mqaf_flags (.clk(clk), .rst(rst), .level(lv), .ae_offset(ao),
    .af_offset(fo), .depth(dp), .skew_bad(skew), .rd_sel(rs), .rd_dev(dv), .rd_q(q),
    .rd_word(wd), .wr_sel(ws), .wr_dev(dv), .wr_q(q), .ae_bus_sel(es), .af_bus_sel(fs),
    .bus_dev(dv), .empty_expansion_in(strap), .almost_empty_flag_n_o(ae),
    .almost_empty_flag_oe(aeo), .almost_full_flag_n_o(af), .almost_full_flag_oe(afo),
    .empty_status_bus_n_o(eb), .empty_status_bus_oe(ebo), .full_status_bus_n_o(fb),
    .full_status_bus_oe(fbo), .rd_data_o(rdat), .rd_data_oe(rdo), .master_o(mst));
  assign mon = {fb[cq], eb[cq], af, ae};
  initial forever #4 clk = ~clk;
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      err_total++;
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // k: 0 read, 1 write, 2 empty bus, 3 full bus
  task automatic sel(input int k, input int d, input int qq);
    @(posedge clk);
    dv <= d[2:0];
    q <= qq[1:0];
    {rs, ws, es, fs} <= 4'h8 >> k;
    @(posedge clk);
    {rs, ws, es, fs} <= 4'h0;
    #1;
  endtask
  task automatic mv(input logic u);
    @(posedge clk);
    {push, pop} <= {u, !u};
    @(posedge clk);
    {push, pop} <= 2'h0;
    #1;
  endtask
  // flag must not move at once, then must arrive within a short bound
  task automatic wait_mon(input int k, input logic v, output int c);
    c = 0;
    cmp(mon[k], !v);
    while (mon[k] !== v && c < 6)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    cmp(mon[k], v);
    if (mon[k] !== v)
      complete_run();
  endtask
  task automatic t_owner();
    cq = 2'h3;
    sel(0, 0, 3);
    cmp({aeo, rdo, ae}, 3'h7);
    sel(1, 0, 3);
    cmp(afo, 1'h1);
    @(posedge clk);
    #1;
    cmp(rdat, 18'h30008);
    sel(2, 0, 0);
    cmp(ebo, 1'h0);
    @(posedge clk);
    #1;
    cmp({ebo, eb}, 5'h1F);
    sel(3, 0, 0);
    cmp(fbo, 1'h0);
    @(posedge clk);
    #1;
    cmp({fbo, fb}, 5'h1F);
    for (int k = 0; k < 4; k++)
      sel(k, 5, 0);
    @(posedge clk);
    #1;
    cmp({aeo, rdo, afo, ebo, fbo}, 5'h00);
  endtask
  task automatic t_empty();
    int c [2];
    int t;
    cq = 2'h2;
    for (int k = 0; k < 4; k++)
      sel(k, 0, 2);
    repeat (3) mv(1'h0);
    for (int s = 0; s < 2; s++)
    begin
      mv(1'h0);
      wait_mon(0, 1'h0, t);
      cmp(eb, 4'hB);
      @(posedge clk);
      skew <= s[0];
      mv(1'h1);
      wait_mon(0, 1'h1, c[s]);
    end
    cmp(c[1], c[0] + 1);
  endtask
  task automatic t_full();
    int c [2];
    int t;
    cq = 2'h1;
    for (int k = 0; k < 4; k++)
      sel(k, 0, 1);
    repeat (19) mv(1'h1);
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clk);
      skew <= s[0];
      mv(1'h1);
      wait_mon(3, 1'h0, t);
      cmp(af, 1'h0);
      mv(1'h0);
      wait_mon(3, 1'h1, c[s]);
    end
    cmp(c[1], c[0] + 1);
    mv(1'h1);
    wait_mon(1, 1'h0, t);
    sel(1, 0, 0);
    wait_mon(1, 1'h1, t);
  endtask
  task automatic t_strap();
    cmp(mst, 1'h1);
    @(posedge clk);
    strap <= 1'h1;
    repeat (4) @(posedge clk);
    #1;
    cmp(mst, 1'h0);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    cmp({ae, af, aeo, afo, eb, ebo, fb, fbo, rdo, mst}, 16'hCF78);
    rst <= 1'h0;
    @(posedge clk);
    t_owner();
    t_empty();
    t_full();
    t_strap();
    complete_run();
  end
endmodule
